// ==== hw/at3_timer.sv ====
`timescale 1ns/1ps
// ============================================================
// 16-bit auto-reload timer, splittable into two 8-bit timers
//
// Contract
// R1: 16-bit wrap reloads and sets high flag
// R2: control bit 3 selects split mode
// R3: system_clock, system_clock/12, synchronised external/8
// R4: 16-bit overflow requests irq when enabled
// R5: low-byte wrap requests irq with low enable
// R6: split counters reload from own reload byte
// R7: split mode run gates only high byte
// R8: per-byte select plus shared external select
// R9: split high wrap sets high flag
// R10: split irq on high, either with enable
// R11: low wrap sets low flag, both modes
// R12: flags cleared only by software writes
// R13: software checks both flags when enabled
// R14: control bit layout, bit 4 zero
// R15: control at 0x91, bit-addressable
// R16: set high flag with irq enable vectors
// R17: bit 0 picks system_clock/12 or external/8
// R18: bit 2 runs counter, bit 1 zero
// R19: 16-bit mode uses low-byte clock select
module at3_timer
  import at3_pkg::*;
(
  input wire logic sys_clk_in, // system clock, 200 MHz
  input wire logic rst_b_in, // synchronous reset, active low
  input wire logic [7:0] sfr_addr_in, // register address
  input wire logic sfr_wr_in, // byte write strobe
  input wire logic [7:0] sfr_wdata_in, // byte write data
  input wire logic sfr_bit_wr_in, // single-bit write strobe
  input wire logic [2:0] sfr_bit_sel_in, // bit index for bit write
  input wire logic sfr_bit_val_in, // bit value for bit write
  input wire logic sfr_rd_in, // read strobe
  input wire logic timer_irq_enable_in, // timer interrupt enable
  input wire logic high_byte_clock_select_in, // 1: system clock for high
  input wire logic low_byte_clock_select_in, // 1: system clock for low
  input wire logic ext_osc_in, // external oscillator level
  output logic [7:0] sfr_rdata_out, // read data, one cycle after strobe
  output logic irq_request_out // interrupt request level
);
  // ============================================================
  // state
  logic [7:0] ctrl_reg, ctrl_next; // control register
  logic [7:0] rl_l_reg, rl_l_next; // reload low byte
  logic [7:0] rl_h_reg, rl_h_next; // reload high byte
  logic [7:0] cnt_l_reg, cnt_l_next; // count low byte
  logic [7:0] cnt_h_reg, cnt_h_next; // count high byte
  logic [7:0] rdata_reg, rdata_next; // read data holding
  logic irq_reg, irq_next; // interrupt request
  logic ext_meta_reg, ext_sync_reg, ext_last_reg; // oscillator sync
  logic ext_edge; // rising edge of synced oscillator
  logic sys12_tick, ext8_tick; // prescaled enables
  logic tick_l, tick_h; // per-byte count enables
  logic ev_ovf_l, ev_ovf_h; // overflow events this cycle
  logic ctrl_wr; // byte write to control
  at3_mode_type mode; // current operating mode

  // ============================================================
  // prescalers
  at3_rate_div #(.DIV_RATIO(AT3_SYS_DIV)) u_sys_div (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(1'b1),
    .pulse_out(sys12_tick) // [R3]
  );

  // only the second sync stage feeds the edge detector
  assign ext_edge = ext_sync_reg & ~ext_last_reg; // [R3]

  at3_rate_div #(.DIV_RATIO(AT3_EXT_DIV)) u_ext_div (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .tick_in(ext_edge),
    .pulse_out(ext8_tick) // [R3]
  );

  // ============================================================
  // clock source selection per byte
  always_comb
  begin
    // external bit picks the slow source, select bit overrides it
    tick_l = low_byte_clock_select_in ? 1'b1 :
      (ctrl_reg[AT3_BIT_XCLK] ? ext8_tick : sys12_tick); // [R8] [R17] [R19]
    tick_h = high_byte_clock_select_in ? 1'b1 :
      (ctrl_reg[AT3_BIT_XCLK] ? ext8_tick : sys12_tick); // [R8] [R17]
    mode = ctrl_reg[AT3_BIT_SPLIT] ? AT3_MODE_SPLIT : AT3_MODE_WIDE; // [R2]
  end

  assign ctrl_wr = sfr_wr_in && (sfr_addr_in == AT3_ADDR_CTRL);

  // ============================================================
  // counting, register writes, flags, read data
  always_comb
  begin
    cnt_l_next = cnt_l_reg;
    cnt_h_next = cnt_h_reg;
    rl_l_next = rl_l_reg;
    rl_h_next = rl_h_reg;
    ctrl_next = ctrl_reg;
    rdata_next = rdata_reg;
    ev_ovf_l = 1'b0;
    ev_ovf_h = 1'b0;
    case (mode)
      AT3_MODE_WIDE:
      begin
        // one counter, clocked from the low-byte source
        if (ctrl_reg[AT3_BIT_RUN] && tick_l) // [R18] [R19]
        begin
          ev_ovf_l = (cnt_l_reg == AT3_BYTE_MAX); // [R11]
          if ({cnt_h_reg, cnt_l_reg} == AT3_WORD_MAX)
          begin
            {cnt_h_next, cnt_l_next} = {rl_h_reg, rl_l_reg}; // [R1]
            ev_ovf_h = 1'b1; // [R1]
          end
          else
          begin
            {cnt_h_next, cnt_l_next} = {cnt_h_reg, cnt_l_reg} + 16'h0001;
          end
        end
      end
      AT3_MODE_SPLIT:
      begin
        // low byte ignores run control
        if (tick_l) // [R7]
        begin
          if (cnt_l_reg == AT3_BYTE_MAX)
          begin
            cnt_l_next = rl_l_reg; // [R6]
            ev_ovf_l = 1'b1; // [R11]
          end
          else
          begin
            cnt_l_next = cnt_l_reg + 8'h01;
          end
        end
        if (ctrl_reg[AT3_BIT_RUN] && tick_h) // [R7]
        begin
          if (cnt_h_reg == AT3_BYTE_MAX)
          begin
            cnt_h_next = rl_h_reg; // [R6]
            ev_ovf_h = 1'b1; // [R9]
          end
          else
          begin
            cnt_h_next = cnt_h_reg + 8'h01;
          end
        end
      end
      default:
      begin
        cnt_l_next = cnt_l_reg;
      end
    endcase
    // software byte writes win over counting
    if (sfr_wr_in)
    begin
      if (sfr_addr_in == AT3_ADDR_CTRL)
      begin
        ctrl_next = sfr_wdata_in; // [R15]
      end
      else if (sfr_addr_in == AT3_ADDR_RL_L)
      begin
        rl_l_next = sfr_wdata_in;
      end
      else if (sfr_addr_in == AT3_ADDR_RL_H)
      begin
        rl_h_next = sfr_wdata_in;
      end
      else if (sfr_addr_in == AT3_ADDR_CNT_L)
      begin
        cnt_l_next = sfr_wdata_in;
      end
      else if (sfr_addr_in == AT3_ADDR_CNT_H)
      begin
        cnt_h_next = sfr_wdata_in;
      end
    end
    // single-bit write to control only
    if (sfr_bit_wr_in && (sfr_addr_in == AT3_ADDR_CTRL))
    begin
      ctrl_next[sfr_bit_sel_in] = sfr_bit_val_in; // [R15]
    end
    ctrl_next = ctrl_next & AT3_CTRL_MASK; // [R14] [R18]
    // hardware only sets flags; a set beats a same-cycle clear
    ctrl_next[AT3_BIT_FLAG_H] = ctrl_next[AT3_BIT_FLAG_H] | ev_ovf_h; // [R12]
    ctrl_next[AT3_BIT_FLAG_L] = ctrl_next[AT3_BIT_FLAG_L] | ev_ovf_l; // [R12]
    // read data, unmapped addresses read zero
    if (sfr_rd_in)
    begin
      if (sfr_addr_in == AT3_ADDR_CTRL)
      begin
        rdata_next = ctrl_reg & AT3_CTRL_MASK; // [R14]
      end
      else if (sfr_addr_in == AT3_ADDR_RL_L)
      begin
        rdata_next = rl_l_reg;
      end
      else if (sfr_addr_in == AT3_ADDR_RL_H)
      begin
        rdata_next = rl_h_reg;
      end
      else if (sfr_addr_in == AT3_ADDR_CNT_L)
      begin
        rdata_next = cnt_l_reg;
      end
      else if (sfr_addr_in == AT3_ADDR_CNT_H)
      begin
        rdata_next = cnt_h_reg;
      end
      else
      begin
        rdata_next = AT3_BYTE_RESET;
      end
    end
    // request follows flags; software must inspect both flags
    irq_next = timer_irq_enable_in & (ctrl_reg[AT3_BIT_FLAG_H] |
      (ctrl_reg[AT3_BIT_LOW_IE] & ctrl_reg[AT3_BIT_FLAG_L])); // [R4] [R5] [R10] [R16]
  end

  // ============================================================
  // registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_reg <= AT3_CTRL_RESET; // [R14]
      rl_l_reg <= AT3_BYTE_RESET;
      rl_h_reg <= AT3_BYTE_RESET;
      cnt_l_reg <= AT3_BYTE_RESET;
      cnt_h_reg <= AT3_BYTE_RESET;
      rdata_reg <= AT3_BYTE_RESET;
      irq_reg <= 1'b0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_last_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      rl_l_reg <= rl_l_next;
      rl_h_reg <= rl_h_next;
      cnt_l_reg <= cnt_l_next;
      cnt_h_reg <= cnt_h_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
      ext_meta_reg <= ext_osc_in; // [R3]
      ext_sync_reg <= ext_meta_reg;
      ext_last_reg <= ext_sync_reg;
    end
  end

  assign sfr_rdata_out = rdata_reg;
  assign irq_request_out = irq_reg;

  // ============================================================
  // assertions
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  a_wide_wrap_reload: assert property (mode == AT3_MODE_WIDE && ctrl_reg[AT3_BIT_RUN]
    && tick_l && {cnt_h_reg, cnt_l_reg} == AT3_WORD_MAX && !sfr_wr_in && !sfr_bit_wr_in
    |=> {cnt_h_reg, cnt_l_reg} == $past({rl_h_reg, rl_l_reg}) && ctrl_reg[7]) // [R1]
    else $error("16-bit wrap did not reload");
  a_split_mode_sel: assert property (ctrl_reg[3] |-> mode == AT3_MODE_SPLIT) // [R2]
    else $error("split bit not honoured");
  a_sys_div_spacing: assert property (sys12_tick |-> ##12 sys12_tick) // [R3]
    else $error("system prescale not twelve");
  a_irq_high_flag: assert property (timer_irq_enable_in && ctrl_reg[7]
    |=> irq_request_out) // [R4]
    else $error("high flag gave no request");
  a_irq_low_flag: assert property (timer_irq_enable_in && ctrl_reg[5] && ctrl_reg[6]
    |=> irq_request_out) // [R5]
    else $error("low flag gave no request");
  a_irq_no_cause: assert property (!ctrl_reg[7] && !(ctrl_reg[5] && ctrl_reg[6])
    |=> !irq_request_out) // [R10]
    else $error("request without cause");
  a_split_low_free: assert property (mode == AT3_MODE_SPLIT && !ctrl_reg[2] && tick_l
    && cnt_l_reg != AT3_BYTE_MAX && !sfr_wr_in
    |=> cnt_l_reg == $past(cnt_l_reg) + 8'h01) // [R7]
    else $error("low byte stopped by run bit");
  a_split_high_hold: assert property (mode == AT3_MODE_SPLIT && !ctrl_reg[2]
    && !sfr_wr_in |=> $stable(cnt_h_reg)) // [R7]
    else $error("high byte moved while stopped");
  a_split_high_wrap: assert property (mode == AT3_MODE_SPLIT && ctrl_reg[2] && tick_h
    && cnt_h_reg == AT3_BYTE_MAX && !sfr_wr_in && !sfr_bit_wr_in
    |=> cnt_h_reg == $past(rl_h_reg) && ctrl_reg[7]) // [R6] [R9]
    else $error("split high wrap wrong");
  a_high_system_clock: assert property (mode == AT3_MODE_SPLIT && ctrl_reg[2]
    && high_byte_clock_select_in && cnt_h_reg != AT3_BYTE_MAX && !sfr_wr_in
    |=> cnt_h_reg == $past(cnt_h_reg) + 8'h01) // [R8]
    else $error("high byte not on system clock");
  a_low_flag_set: assert property (ev_ovf_l |=> ctrl_reg[6]) // [R11]
    else $error("low wrap missed flag");
  a_flag_sticky: assert property (ctrl_reg[7] && !ctrl_wr && !sfr_bit_wr_in
    |=> ctrl_reg[7]) // [R12]
    else $error("high flag cleared by hardware");
  a_ctrl_unused_zero: assert property (ctrl_reg[4] == 1'b0 && ctrl_reg[1] == 1'b0) // [R14] [R18]
    else $error("unused control bit set");

  c_wide_wrap: cover property (mode == AT3_MODE_WIDE && ev_ovf_h);
  c_split_both: cover property (mode == AT3_MODE_SPLIT && ev_ovf_l && ev_ovf_h);
  c_ext_tick: cover property (ext8_tick && ctrl_reg[0]);
  c_irq_low: cover property (irq_request_out && ctrl_reg[5] && !ctrl_reg[7]);
endmodule : at3_timer

// ==== hw/at3_pkg.sv ====
// ============================================================
// shared constants for the auto-reload timer
package at3_pkg;
  // ============================================================
  // special function register addresses
  localparam logic [7:0] AT3_ADDR_CTRL = 8'h91; // control, bit-addressable
  localparam logic [7:0] AT3_ADDR_RL_L = 8'h92; // reload low byte
  localparam logic [7:0] AT3_ADDR_RL_H = 8'h93; // reload high byte
  localparam logic [7:0] AT3_ADDR_CNT_L = 8'h94; // count low byte
  localparam logic [7:0] AT3_ADDR_CNT_H = 8'h95; // count high byte

  // ============================================================
  // control register field positions
  localparam int AT3_BIT_FLAG_H = 7; // high overflow flag
  localparam int AT3_BIT_FLAG_L = 6; // low overflow flag
  localparam int AT3_BIT_LOW_IE = 5; // low overflow irq enable
  localparam int AT3_BIT_SPLIT = 3; // split mode select
  localparam int AT3_BIT_RUN = 2; // run control
  localparam int AT3_BIT_XCLK = 0; // external clock select
  // bits 4 and 1 are unused: never stored, read zero
  localparam logic [7:0] AT3_CTRL_MASK = 8'hed;

  // ============================================================
  // reset values
  localparam logic [7:0] AT3_CTRL_RESET = 8'h00;
  localparam logic [7:0] AT3_BYTE_RESET = 8'h00;
  localparam logic [7:0] AT3_BYTE_MAX = 8'hff; // wrap point of one byte
  localparam logic [15:0] AT3_WORD_MAX = 16'hffff; // wrap point of 16 bits

  // ============================================================
  // count clock prescale ratios
  localparam int AT3_SYS_DIV = 12; // system clock divider
  localparam int AT3_EXT_DIV = 8; // external oscillator divider

  // ============================================================
  // operating mode, one-hot
  typedef enum logic [1:0] {
    AT3_MODE_WIDE = 2'b01, // one 16-bit counter
    AT3_MODE_SPLIT = 2'b10 // two 8-bit counters
  } at3_mode_type;
endpackage : at3_pkg

// ==== hw/at3_rate_div.sv ====
`timescale 1ns/1ps
// ============================================================
// divides a stream of tick enables into one pulse per ratio ticks
module at3_rate_div
  import at3_pkg::*;
#(
  parameter int DIV_RATIO = 12 // ticks per output pulse
)(
  input wire logic sys_clk_in, // system clock
  input wire logic rst_b_in, // synchronous reset, active low
  input wire logic tick_in, // one-cycle input enable
  output logic pulse_out // one-cycle enable every ratio ticks
);
  localparam int CW = (DIV_RATIO > 2) ? $clog2(DIV_RATIO) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV_RATIO - 1);

  // ============================================================
  // elaboration check
  generate
    if (DIV_RATIO < 2)
    begin : g_bad_ratio
      $error("at3_rate_div: ratio below two");
    end
  endgenerate

  logic [CW-1:0] cnt_reg; // ticks seen in this period
  logic [CW-1:0] cnt_next;
  logic pulse_reg; // registered pulse
  logic pulse_next;

  // ============================================================
  // next count and pulse
  always_comb
  begin
    cnt_next = cnt_reg;
    pulse_next = 1'b0;
    if (tick_in)
    begin
      if (cnt_reg == LAST)
      begin
        cnt_next = '0;
        pulse_next = 1'b1; // period complete
      end
      else
      begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  // ============================================================
  // registers
  always_ff @(posedge sys_clk_in)
  begin
    if (!rst_b_in)
    begin
      cnt_reg <= '0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pulse_out = pulse_reg;
endmodule : at3_rate_div

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
// ============================================================
// self-checking bench for the auto-reload timer
module tb_top
  import at3_pkg::*;
;
  logic sys_clk_in = 1'b0; // 200 MHz system clock
  logic rst_b_in = 1'b0; // held low at start
  logic [7:0] sfr_addr_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic sfr_bit_wr_in = 1'b0;
  logic [2:0] sfr_bit_sel_in = 3'h0;
  logic sfr_bit_val_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic timer_irq_enable_in = 1'b1; // global enable, mostly on
  logic high_byte_clock_select_in = 1'b0;
  logic low_byte_clock_select_in = 1'b0;
  logic ext_osc_in = 1'b0; // idle until the external test
  logic [7:0] sfr_rdata_out;
  logic irq_request_out;
  int mismatches = 0;
  int comparisons = 0;
  logic [7:0] rd_val; // last read result
  logic [7:0] addr_v; // loop address
  // packed rows: address, write data, expected readback
  logic [23:0] rows [8] = '{24'h91ffed, 24'h910000, 24'h925a5a, 24'h93a5a5,
    24'h943c3c, 24'h95c3c3, 24'h967700, 24'h901100};

  // ============================================================
  // clock and device
  always #2.5 sys_clk_in = ~sys_clk_in;

  at3_timer uut (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in),
    .sfr_wdata_in(sfr_wdata_in),
    .sfr_bit_wr_in(sfr_bit_wr_in),
    .sfr_bit_sel_in(sfr_bit_sel_in),
    .sfr_bit_val_in(sfr_bit_val_in),
    .sfr_rd_in(sfr_rd_in),
    .timer_irq_enable_in(timer_irq_enable_in),
    .high_byte_clock_select_in(high_byte_clock_select_in),
    .low_byte_clock_select_in(low_byte_clock_select_in),
    .ext_osc_in(ext_osc_in),
    .sfr_rdata_out(sfr_rdata_out),
    .irq_request_out(irq_request_out)
  );

  // ============================================================
  // bus tasks and comparison
  // one-cycle byte write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_wr_in <= 1'b0;
  endtask : wr

  // single-bit write, control register only
  task automatic bitw(input logic [2:0] s, input logic v);
    @(posedge sys_clk_in);
    sfr_addr_in <= AT3_ADDR_CTRL;
    sfr_bit_sel_in <= s;
    sfr_bit_val_in <= v;
    sfr_bit_wr_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_bit_wr_in <= 1'b0;
  endtask : bitw

  // read strobe; data sampled a full cycle later since it holds
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge sys_clk_in);
    sfr_rd_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    rd_val = sfr_rdata_out;
  endtask : rd

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // bounded wait for the request line
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq_request_out !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    check({7'h0, irq_request_out}, 8'h01, "irq wait");
  endtask : wait_irq

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // ============================================================
  // watchdog, far beyond the few hundred cycles needed
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    mismatches++;
    end_of_test();
  end

  // ============================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    // reset values of every mapped register
    for (addr_v = AT3_ADDR_CTRL; addr_v <= AT3_ADDR_CNT_H; addr_v++)
    begin
      rd(addr_v);
      check(rd_val, 8'h00, "reset value");
    end
    $display("test reset done");
    // table: write then read back, unused bits and unmapped places
    foreach (rows[i])
    begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      check(rd_val, rows[i][7:0], "readback");
    end
    $display("test register table done");
    // 16-bit wrap on system_clock/12, high select set opposite on purpose
    wr(AT3_ADDR_RL_L, 8'h34);
    wr(AT3_ADDR_RL_H, 8'h12);
    wr(AT3_ADDR_CNT_L, 8'hfe);
    wr(AT3_ADDR_CNT_H, 8'hff);
    high_byte_clock_select_in <= 1'b1;
    wr(AT3_ADDR_CTRL, 8'h04);
    wait_irq(100);
    bitw(3'd2, 1'b0);
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'hc0, "wide flags");
    rd(AT3_ADDR_CNT_H);
    check(rd_val, 8'h12, "wide reload high");
    rd(AT3_ADDR_CNT_L);
    check(rd_val & 8'hfe, 8'h34, "wide reload low");
    repeat (40) @(posedge sys_clk_in);
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'hc0, "flags kept");
    timer_irq_enable_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
    check({7'h0, irq_request_out}, 8'h00, "irq masked");
    timer_irq_enable_in <= 1'b1;
    bitw(3'd7, 1'b0);
    bitw(3'd6, 1'b0);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check({7'h0, irq_request_out}, 8'h00, "irq cleared");
    $display("test wide wrap done");
    // low byte wrap with low irq enable, carry into high byte
    wr(AT3_ADDR_CNT_H, 8'h00);
    wr(AT3_ADDR_CNT_L, 8'hfd);
    low_byte_clock_select_in <= 1'b1;
    high_byte_clock_select_in <= 1'b0;
    wr(AT3_ADDR_CTRL, 8'h24);
    wait_irq(50);
    bitw(3'd2, 1'b0);
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'h60, "low flag only");
    rd(AT3_ADDR_CNT_H);
    check(rd_val, 8'h01, "carry");
    $display("test low wrap done");
    // split mode: low runs without run control, high held
    wr(AT3_ADDR_RL_L, 8'h80);
    wr(AT3_ADDR_RL_H, 8'h40);
    wr(AT3_ADDR_CNT_H, 8'hfe);
    wr(AT3_ADDR_CNT_L, 8'hfe);
    high_byte_clock_select_in <= 1'b1;
    wr(AT3_ADDR_CTRL, 8'h08);
    repeat (20) @(posedge sys_clk_in);
    #1;
    check({7'h0, irq_request_out}, 8'h00, "no low irq");
    low_byte_clock_select_in <= 1'b0;
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'h48, "split low flag");
    rd(AT3_ADDR_CNT_H);
    check(rd_val, 8'hfe, "high held");
    rd(AT3_ADDR_CNT_L);
    check({7'h0, rd_val[7]}, 8'h01, "low own reload");
    bitw(3'd2, 1'b1);
    wait_irq(20);
    bitw(3'd2, 1'b0);
    // reload 0x40, then three more system ticks before the stop lands
    rd(AT3_ADDR_CNT_H);
    check(rd_val, 8'h43, "high own reload");
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'hc8, "split high flag");
    // low overflow alone raises the request once enabled
    wr(AT3_ADDR_CTRL, 8'h28);
    low_byte_clock_select_in <= 1'b1;
    wr(AT3_ADDR_CNT_L, 8'hfe);
    wait_irq(20);
    // service routine looks at both flags: only the low one is up
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'h68, "irq source flags");
    $display("test split done");
    // external clock: 16 rising edges give exactly two ticks
    // source switched first, so no stray divided tick lands after the clear
    low_byte_clock_select_in <= 1'b0;
    wr(AT3_ADDR_CTRL, 8'h09);
    wr(AT3_ADDR_CNT_L, 8'h00);
    repeat (16)
    begin
      repeat (4) @(posedge sys_clk_in);
      ext_osc_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      ext_osc_in <= 1'b0;
    end
    repeat (10) @(posedge sys_clk_in);
    rd(AT3_ADDR_CNT_L);
    check(rd_val, 8'h02, "external ticks");
    // system_clock/12: about ten ticks in 120 cycles, phase unknown
    wr(AT3_ADDR_CTRL, 8'h08);
    wr(AT3_ADDR_CNT_L, 8'h00);
    repeat (120) @(posedge sys_clk_in);
    rd(AT3_ADDR_CNT_L);
    check({7'h0, rd_val >= 8'h09 && rd_val <= 8'h0b}, 8'h01, "divided ticks");
    // unused bits ignore bit writes
    bitw(3'd4, 1'b1);
    bitw(3'd1, 1'b1);
    rd(AT3_ADDR_CTRL);
    check(rd_val, 8'h08, "unused bits");
    $display("test clocks done");
    end_of_test();
  end
endmodule : tb_top
